/* File: include/half_bridge_consts.vh */
// Constants of the triple half-bridge serial control block.
// Assumes a 250 MHz core clock; all counts are derived from it.
`ifndef HALF_BRIDGE_CONSTS_VH
`define HALF_BRIDGE_CONSTS_VH

// Word size on the serial link
`define WORD_BITS        16
`define BIT_COUNT_W      5

// Control word fields
`define CTL_CLEAR_BIT    0
`define CTL_SW_LSB       1
`define CTL_SW_MSB       6
`define CTL_OCS_BIT      13

// Control reset values
`define CTL_SW_RESET     6'h00
`define CTL_OCS_RESET    1'b1

// Status word fields
`define STS_PREWARN_BIT  0
`define STS_SW_LSB       1
`define STS_SW_MSB       6
`define STS_SHORT_BIT    13
`define STS_OPEN_BIT     14
`define STS_SUPPLY_BIT   15

// Words reserved for internal test modes, never sent by the controller
`define TEST_WORD_A      16'hF800
`define TEST_WORD_B      16'hE600
`define TEST_WORD_C      16'hE180

// Timing
`define CLK_MHZ          250
`define UV_DELAY_NS      10000
`define SD_DELAY_NS      10000
`define POR_NS           2000
`define UV_DELAY_CYC     ((`UV_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define SD_DELAY_CYC     ((`SD_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define POR_CYC          ((`POR_NS * `CLK_MHZ + 999) / 1000)
`define TIMER_W          12

`endif

/* File: verilog/pin_sync.v */
// Two-stage synchroniser for a group of independent level inputs.
// Assumes every bit is a slow level relative to the core clock.
`timescale 1ns/10ps
module pin_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clock,
	input  wire             reset_n,
	// Levels
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_sync_out
);

	reg [WIDTH-1:0] stage1_reg;

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1_reg   <= {WIDTH{1'b0}};
			pin_sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1_reg   <= pin_in;
			pin_sync_out <= stage1_reg;
		end
	end

endmodule

/* File: verilog/serial_link.v */
// Serial shift engine: samples data on serial clock falls, drives out on rises.
// Assumes select, clock and data are already synchronised to the core clock.
`timescale 1ns/10ps
`include "half_bridge_consts.vh"
module serial_link (
	// Clock and reset
	input  wire                    clock,
	input  wire                    reset_n,
	// Control
	input  wire                    link_on,
	// Synchronised pins
	input  wire                    select_n_s,
	input  wire                    serial_clk_s,
	input  wire                    serial_in_s,
	// Status snapshot source
	input  wire [`WORD_BITS-1:0]   status_word,
	// Received word
	output reg                     word_strobe,
	output reg  [`WORD_BITS-1:0]   word_data,
	// Serial output
	output reg                     serial_out,
	output reg                     serial_out_en
);

	reg                    sel_prev_reg;
	reg                    sclk_prev_reg;
	reg                    active_reg;
	reg [`WORD_BITS-1:0]   shift_reg;
	reg [`BIT_COUNT_W-1:0] count_reg;

	wire sel_fall  = sel_prev_reg & ~select_n_s;
	wire sclk_fall = sclk_prev_reg & ~serial_clk_s;
	wire sclk_rise = ~sclk_prev_reg & serial_clk_s;

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_prev_reg  <= 1'b1;
			sclk_prev_reg <= 1'b0;
			active_reg    <= 1'b0;
			shift_reg     <= {`WORD_BITS{1'b0}};
			count_reg     <= {`BIT_COUNT_W{1'b0}};
			word_strobe   <= 1'b0;
			word_data     <= {`WORD_BITS{1'b0}};
			serial_out    <= 1'b0;
			serial_out_en <= 1'b0;
		end
		else
		begin
			sel_prev_reg  <= select_n_s;
			sclk_prev_reg <= serial_clk_s;
			word_strobe   <= 1'b0;
			if (!link_on)
			begin
				active_reg    <= 1'b0;
				serial_out_en <= 1'b0;
			end
			else if (sel_fall)
			begin
				// Snapshot status, prewarning bit visible at once
				active_reg    <= 1'b1;
				shift_reg     <= status_word;
				serial_out    <= status_word[0];
				serial_out_en <= 1'b1;
				count_reg     <= {`BIT_COUNT_W{1'b0}};
			end
			else if (active_reg && select_n_s)
			begin
				// Apply only a complete word; an aborted frame changes nothing
				active_reg    <= 1'b0;
				serial_out_en <= 1'b0;
				word_strobe   <= (count_reg == `WORD_BITS);
				word_data     <= shift_reg;
			end
			else if (active_reg)
			begin
				if (sclk_fall)
				begin
					// LSB first, sampled on falling edges
					shift_reg <= {serial_in_s, shift_reg[`WORD_BITS-1:1]};
					if (count_reg != {`BIT_COUNT_W{1'b1}})
						count_reg <= count_reg + 1'b1;
				end
				if (sclk_rise)
					serial_out <= shift_reg[0];
			end
		end
	end

endmodule

/* File: verilog/half_bridge_serial_ctrl.v */
// Control and status logic of a serially commanded triple half-bridge driver.
// Assumes analog detectors deliver level inputs asynchronous to the core clock.
`timescale 1ns/10ps
`include "half_bridge_consts.vh"
module half_bridge_serial_ctrl (
	// Clock and reset
	input  wire       clock,
	input  wire       reset_n,
	// Serial interface pins
	input  wire       select_n,
	input  wire       serial_clk,
	input  wire       serial_in,
	output wire       serial_out,
	output wire       serial_out_en,
	// Standby control pin
	input  wire       operate_enable,
	// Analog detector levels
	input  wire       supply_under,
	input  wire       prewarn_hot,
	input  wire       prewarn_cool,
	input  wire       shutdown_hot,
	input  wire       shutdown_cool,
	input  wire [5:0] open_load_det,
	input  wire [5:0] overcurrent_det,
	// Switch drive, bit order low_switch_1 .. high_switch_3
	output reg  [5:0] switch_on,
	output reg        overcurrent_shutdown_active
);

	localparam [1:0] ST_STANDBY = 2'b00;
	localparam [1:0] ST_POR     = 2'b01;
	localparam [1:0] ST_RUN     = 2'b10;

	localparam integer UV_I  = `UV_DELAY_CYC;
	localparam integer SD_I  = `SD_DELAY_CYC;
	localparam integer POR_I = `POR_CYC;
	localparam [`TIMER_W-1:0] UV_CYC  = UV_I[`TIMER_W-1:0];
	localparam [`TIMER_W-1:0] SD_CYC  = SD_I[`TIMER_W-1:0];
	localparam [`TIMER_W-1:0] POR_CYC = POR_I[`TIMER_W-1:0];

	// Saturating timer step: counts while the condition holds, else restarts
	function [`TIMER_W-1:0] timer_step;
		input                cond;
		input [`TIMER_W-1:0] count;
		input [`TIMER_W-1:0] limit;
		begin
			if (!cond)
				timer_step = {`TIMER_W{1'b0}};
			else if (count >= limit)
				timer_step = count;
			else
				timer_step = count + 1'b1;
		end
	endfunction

	// Condition has lasted longer than the limit
	function timer_done;
		input                cond;
		input [`TIMER_W-1:0] count;
		input [`TIMER_W-1:0] limit;
		begin
			timer_done = cond && (count >= limit);
		end
	endfunction

	// Synchronised inputs; select is carried inverted so reset reads as deselected
	wire [20:0] raw_in;
	wire [20:0] sync_in;
	assign raw_in = {overcurrent_det, open_load_det, shutdown_cool, shutdown_hot,
		prewarn_cool, prewarn_hot, supply_under, operate_enable,
		serial_in, serial_clk, ~select_n};

	pin_sync #(
		.WIDTH (21)
	) u_sync (
		.clock        (clock),
		.reset_n      (reset_n),
		.pin_in       (raw_in),
		.pin_sync_out (sync_in)
	);

	wire       select_n_s     = ~sync_in[0];
	wire       serial_clk_s   = sync_in[1];
	wire       serial_in_s    = sync_in[2];
	wire       operate_s      = sync_in[3];
	wire       supply_under_s = sync_in[4];
	wire       prewarn_hot_s  = sync_in[5];
	wire       prewarn_cool_s = sync_in[6];
	wire       shut_hot_s     = sync_in[7];
	wire       shut_cool_s    = sync_in[8];
	wire [5:0] open_load_s    = sync_in[14:9];
	wire [5:0] overcurrent_s  = sync_in[20:15];

	// State and registers
	reg [1:0]          state_reg;
	reg [`TIMER_W-1:0] por_count_reg;
	reg [5:0]          switch_cmd_reg;
	reg                ocs_reg;
	reg                supply_fail_reg;
	reg                open_load_reg;
	reg                short_reg;
	reg                prewarn_reg;
	reg                thermal_off_reg;
	reg [5:0]          trip_mask_reg;
	reg [`TIMER_W-1:0] uv_count_reg;
	reg [`TIMER_W-1:0] ol_count_reg;
	reg [`TIMER_W-1:0] oc_count_reg [0:5];

	wire                  running = (state_reg == ST_RUN);
	wire                  word_strobe;
	wire [`WORD_BITS-1:0] word_data;
	wire [`WORD_BITS-1:0] status_word;

	wire cmd_take  = running && word_strobe;
	wire clear_cmd = cmd_take && word_data[`CTL_CLEAR_BIT];

	// Undervoltage lasting longer than the delay
	wire uv_active = timer_done(supply_under_s, uv_count_reg, UV_CYC);

	// Open load on any switch that is on
	wire ol_cond  = |(open_load_s & switch_on);
	wire ol_event = timer_done(ol_cond, ol_count_reg, SD_CYC);

	// Overcurrent per switch after the shutdown delay
	reg [5:0] oc_event;
	integer   i;
	always @*
	begin
		oc_event = 6'h00;
		for (i = 0; i < 6; i = i + 1)
			oc_event[i] = timer_done(overcurrent_s[i] & switch_on[i], oc_count_reg[i],
				SD_CYC);
	end

	// Switch gating: supply, thermal and short-circuit trips
	wire [5:0] switch_next = (running && !uv_active && !thermal_off_reg)
		? (switch_cmd_reg & ~trip_mask_reg) : 6'h00;

	// Status word, unused bits low
	assign status_word = {supply_fail_reg, open_load_reg, short_reg, 6'h00,
		switch_on, prewarn_reg};

	// Power mode sequencer
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg     <= ST_STANDBY;
			por_count_reg <= {`TIMER_W{1'b0}};
		end
		else
		begin
			case (state_reg)
				ST_STANDBY:
				begin
					por_count_reg <= {`TIMER_W{1'b0}};
					if (operate_s)
						state_reg <= ST_POR;
				end
				ST_POR:
				begin
					if (!operate_s)
						state_reg <= ST_STANDBY;
					else if (por_count_reg >= POR_CYC - 1'b1)
						state_reg <= ST_RUN;
					else
						por_count_reg <= por_count_reg + 1'b1;
				end
				ST_RUN:
				begin
					if (!operate_s)
						state_reg <= ST_STANDBY;
				end
				default:
				begin
					state_reg <= ST_STANDBY;
				end
			endcase
		end
	end

	// Control word
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			switch_cmd_reg <= `CTL_SW_RESET;
			ocs_reg        <= `CTL_OCS_RESET;
		end
		else if (!running)
		begin
			switch_cmd_reg <= `CTL_SW_RESET;
			ocs_reg        <= `CTL_OCS_RESET;
		end
		else if (cmd_take)
		begin
			// Only switch and shutdown fields are kept
			switch_cmd_reg <= word_data[`CTL_SW_MSB:`CTL_SW_LSB];
			ocs_reg        <= word_data[`CTL_OCS_BIT];
		end
	end

	// Detection timers
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			uv_count_reg <= {`TIMER_W{1'b0}};
			ol_count_reg <= {`TIMER_W{1'b0}};
		end
		else
		begin
			uv_count_reg <= timer_step(running & supply_under_s, uv_count_reg, UV_CYC);
			ol_count_reg <= timer_step(running & ol_cond, ol_count_reg, SD_CYC);
		end
	end

	// Overcurrent timers, one per switch, all in one process
	integer j;
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (j = 0; j < 6; j = j + 1)
				oc_count_reg[j] <= {`TIMER_W{1'b0}};
		end
		else
		begin
			for (j = 0; j < 6; j = j + 1)
				oc_count_reg[j] <= timer_step(running & overcurrent_s[j] & switch_on[j],
					oc_count_reg[j], SD_CYC);
		end
	end

	// Latched fault flags; a new event wins over a clear
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			supply_fail_reg <= 1'b0;
			open_load_reg   <= 1'b0;
			short_reg       <= 1'b0;
			trip_mask_reg   <= 6'h00;
		end
		else if (!running)
		begin
			supply_fail_reg <= 1'b0;
			open_load_reg   <= 1'b0;
			short_reg       <= 1'b0;
			trip_mask_reg   <= 6'h00;
		end
		else
		begin
			if (uv_active)
				supply_fail_reg <= 1'b1;
			else if (clear_cmd)
				supply_fail_reg <= 1'b0;
			if (ol_event)
				open_load_reg <= 1'b1;
			else if (clear_cmd)
				open_load_reg <= 1'b0;
			if (|oc_event)
				short_reg <= 1'b1;
			else if (clear_cmd)
				short_reg <= 1'b0;
			if (ocs_reg)
				trip_mask_reg <= (clear_cmd ? 6'h00 : trip_mask_reg) | oc_event;
			else if (clear_cmd)
				trip_mask_reg <= 6'h00;
		end
	end

	// Thermal prewarning and shutdown
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prewarn_reg     <= 1'b0;
			thermal_off_reg <= 1'b0;
		end
		else if (!running)
		begin
			prewarn_reg     <= 1'b0;
			thermal_off_reg <= 1'b0;
		end
		else
		begin
			if (prewarn_hot_s)
				prewarn_reg <= 1'b1;
			else if (prewarn_cool_s)
				prewarn_reg <= 1'b0;
			if (shut_hot_s)
				thermal_off_reg <= 1'b1;
			else if (clear_cmd && shut_cool_s)
				thermal_off_reg <= 1'b0;
		end
	end

	// Switch drive
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			switch_on                   <= 6'h00;
			overcurrent_shutdown_active <= 1'b0;
		end
		else
		begin
			switch_on                   <= switch_next;
			overcurrent_shutdown_active <= running & ocs_reg;
		end
	end

	// Serial engine
	serial_link u_link (
		.clock         (clock),
		.reset_n       (reset_n),
		.link_on       (running),
		.select_n_s    (select_n_s),
		.serial_clk_s  (serial_clk_s),
		.serial_in_s   (serial_in_s),
		.status_word   (status_word),
		.word_strobe   (word_strobe),
		.word_data     (word_data),
		.serial_out    (serial_out),
		.serial_out_en (serial_out_en)
	);

endmodule

/* File: verif/hb_checker_assertions.sv */
// Port checks for the half-bridge control block.
// Assumes frames start 600 cycles after operate_enable rises.
`timescale 1ns/10ps
module hb_checker (
	// Clock and reset
	input wire       clock,
	input wire       reset_n,
	// Serial and standby pins
	input wire       select_n,
	input wire       serial_clk,
	input wire       serial_in,
	input wire       serial_out,
	input wire       serial_out_en,
	input wire       operate_enable,
	// Detectors
	input wire       supply_under,
	input wire       prewarn_hot,
	input wire       prewarn_cool,
	input wire       shutdown_hot,
	input wire       shutdown_cool,
	input wire [5:0] open_load_det,
	input wire [5:0] overcurrent_det,
	// Drive
	input wire [5:0] switch_on,
	input wire       overcurrent_shutdown_active
);
	reg  [11:0] run_cnt;
	reg  [11:0] uv_cnt;
	reg  [11:0] oc_cnt;
	wire        oc_hit = overcurrent_shutdown_active && |(overcurrent_det & switch_on);
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_cnt <= 12'h000;
			uv_cnt <= 12'h000;
			oc_cnt <= 12'h000;
		end
		else
		begin
			run_cnt <= operate_enable ? run_cnt + {11'h000, run_cnt != 12'hFFF} : 12'h000;
			uv_cnt <= supply_under ? uv_cnt + {11'h000, uv_cnt != 12'hFFF} : 12'h000;
			oc_cnt <= oc_hit ? oc_cnt + {11'h000, oc_cnt != 12'hFFF} : 12'h000;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_frame_open;
		$fell(select_n) && run_cnt > 12'h258;
	endsequence
	sequence s_standby;
		!operate_enable [*5];
	endsequence
	a_out_enable: assert property (s_frame_open |-> ##[1:6] (serial_out_en || select_n))
		else $error("output not enabled after select");
	a_out_tristate: assert property (select_n [*8] |-> !serial_out_en)
		else $error("output driven while deselected");
	a_out_hold: assert property ((!serial_clk && !select_n) [*8] |-> $stable(serial_out))
		else $error("output moved without clock rise");
	a_standby_off: assert property (s_standby |-> switch_on == 6'h00 && !overcurrent_shutdown_active)
		else $error("switch on in standby");
	a_standby_quiet: assert property (s_standby |-> !serial_out_en)
		else $error("output enabled in standby");
	a_por_state: assert property (run_cnt == 12'h230 |-> overcurrent_shutdown_active && switch_on == 6'h00)
		else $error("wrong state after power-on");
	a_supply_cut: assert property (uv_cnt == 12'h9CE |-> switch_on == 6'h00)
		else $error("switch on during undervoltage");
	a_thermal_off: assert property (shutdown_hot [*8] |-> switch_on == 6'h00)
		else $error("switch on while overheated");
	a_trip_bound: assert property (oc_cnt <= 12'h9CE)
		else $error("overcurrent not tripped in time");
endmodule
bind half_bridge_serial_ctrl hb_checker u_chk (.clock(clock), .reset_n(reset_n),
	.select_n(select_n), .serial_clk(serial_clk), .serial_in(serial_in),
	.serial_out(serial_out), .serial_out_en(serial_out_en), .operate_enable(operate_enable),
	.supply_under(supply_under), .prewarn_hot(prewarn_hot), .prewarn_cool(prewarn_cool),
	.shutdown_hot(shutdown_hot), .shutdown_cool(shutdown_cool), .open_load_det(open_load_det),
	.overcurrent_det(overcurrent_det), .switch_on(switch_on),
	.overcurrent_shutdown_active(overcurrent_shutdown_active));

/* File: verif/serial_master.sv */
// Behavioural serial master standing in for the microcontroller.
// Assumes serial_out_line already resolves the tri-state output.
`timescale 1ns/10ps
module serial_master (
	// Serial pins
	output reg  select_n,
	output reg  serial_clk,
	output reg  serial_in,
	input  wire serial_out_line
);
	initial
	begin
		select_n = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end
	// Sends nbits LSB first; test-mode words are never sent
	task xfer(input [15:0] ctl, input integer nbits, output [15:0] sts);
		integer i;
		begin
			sts = 16'h0000;
			select_n = 1'b0;
			#32;
			for (i = 0; i < nbits; i = i + 1)
			begin
				serial_clk = 1'b1;
				serial_in = ctl[i];
				#32;
				serial_clk = 1'b0;
				sts[i] = serial_out_line;
				#32;
			end
			select_n = 1'b1;
			serial_in = 1'b0;
			#64;
		end
	endtask
endmodule

/* File: verif/half_bridge_serial_ctrl_bench.sv */
// Self-checking bench for the half-bridge control block.
// Assumes the serial master model and the bound checker.
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count = check_count + 1; if ((got) !== (exp)) begin \
	errors = errors + 1; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module half_bridge_serial_ctrl_bench;
	reg         clock = 1'b0;
	reg         reset_n = 1'b0;
	reg         operate_enable = 1'b0;
	reg         supply_under = 1'b0;
	reg         prewarn_hot = 1'b0;
	reg         prewarn_cool = 1'b1;
	reg         shutdown_hot = 1'b0;
	reg         shutdown_cool = 1'b1;
	reg  [5:0]  open_load_det = 6'h00;
	reg  [5:0]  overcurrent_det = 6'h00;
	reg  [15:0] sts;
	integer     errors = 0;
	integer     check_count = 0;
	wire        select_n;
	wire        serial_clk;
	wire        serial_in;
	wire        serial_out;
	wire        serial_out_en;
	wire [5:0]  switch_on;
	wire        ocs_active;
	wire        do_line = serial_out_en ? serial_out : 1'bz;
	always #2 clock = ~clock;
	serial_master m (.select_n(select_n), .serial_clk(serial_clk), .serial_in(serial_in),
		.serial_out_line(do_line));
	half_bridge_serial_ctrl uut (.clock(clock), .reset_n(reset_n), .select_n(select_n),
		.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_en(serial_out_en), .operate_enable(operate_enable),
		.supply_under(supply_under), .prewarn_hot(prewarn_hot), .prewarn_cool(prewarn_cool),
		.shutdown_hot(shutdown_hot), .shutdown_cool(shutdown_cool),
		.open_load_det(open_load_det), .overcurrent_det(overcurrent_det),
		.switch_on(switch_on), .overcurrent_shutdown_active(ocs_active));
	task w(input integer n);
		begin
			repeat (n) @(posedge clock);
			#1;
		end
	endtask
	function [15:0] ctl(input overcurrent_shutdown_en, input [5:0] sw, input clr);
		ctl = {2'b00, overcurrent_shutdown_en, 6'h00, sw, clr};
	endfunction
	function [15:0] st(input pw, input [5:0] sw, input sh, input ol, input sf);
		st = {sf, ol, sh, 6'h00, sw, pw};
	endfunction
	task rd(input [15:0] word, input [15:0] exp);
		begin
			m.xfer(word, 16, sts);
			`CHK(sts, exp)
			w(8);
		end
	endtask
	task results;
		begin
			$display("Checks %0d, mismatches %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial
	begin
		#300000;
		errors = errors + 1;
		results;
	end
	initial
	begin
		w(3);
		reset_n = 1'b1;
		w(2);
		operate_enable = 1'b1;
		w(600);
		`CHK(ocs_active, 1'b1)
		rd(ctl(1, 6'h15, 0) | 16'hDF80, 16'h0000);
		`CHK(switch_on, 6'h15)
		rd(ctl(1, 6'h2A, 0) | 16'hDF80, st(0, 6'h15, 0, 0, 0));
		`CHK(switch_on, 6'h2A)
		$display("Switch words done");
		prewarn_cool = 1'b0;
		prewarn_hot = 1'b1;
		w(8);
		prewarn_hot = 1'b0;
		m.xfer(ctl(1, 6'h00, 0), 1, sts);
		`CHK(sts[0], 1'b1)
		w(8);
		`CHK(switch_on, 6'h2A)
		prewarn_cool = 1'b1;
		w(8);
		rd(ctl(1, 6'h01, 0), st(0, 6'h2A, 0, 0, 0));
		$display("Prewarning done");
		open_load_det = 6'h01;
		w(2600);
		open_load_det = 6'h00;
		rd(ctl(1, 6'h01, 0), st(0, 6'h01, 0, 1, 0));
		rd(ctl(1, 6'h01, 1), st(0, 6'h01, 0, 1, 0));
		rd(ctl(1, 6'h01, 0), st(0, 6'h01, 0, 0, 0));
		$display("Open load done");
		overcurrent_det = 6'h01;
		w(2600);
		`CHK(switch_on, 6'h00)
		overcurrent_det = 6'h00;
		rd(ctl(1, 6'h01, 0), st(0, 6'h00, 1, 0, 0));
		`CHK(switch_on, 6'h00)
		rd(ctl(1, 6'h01, 1), st(0, 6'h00, 1, 0, 0));
		`CHK(switch_on, 6'h01)
		rd(ctl(0, 6'h01, 0), st(0, 6'h01, 0, 0, 0));
		`CHK(ocs_active, 1'b0)
		overcurrent_det = 6'h01;
		w(2600);
		`CHK(switch_on, 6'h01)
		overcurrent_det = 6'h00;
		rd(ctl(1, 6'h01, 1), st(0, 6'h01, 1, 0, 0));
		$display("Short circuit done");
		supply_under = 1'b1;
		w(2600);
		`CHK(switch_on, 6'h00)
		supply_under = 1'b0;
		w(8);
		`CHK(switch_on, 6'h01)
		rd(ctl(1, 6'h01, 0), st(0, 6'h01, 0, 0, 1));
		shutdown_cool = 1'b0;
		shutdown_hot = 1'b1;
		w(8);
		shutdown_hot = 1'b0;
		w(8);
		`CHK(switch_on, 6'h00)
		rd(ctl(1, 6'h01, 1), st(0, 6'h00, 0, 0, 1));
		`CHK(switch_on, 6'h00)
		shutdown_cool = 1'b1;
		w(8);
		rd(ctl(1, 6'h01, 1), st(0, 6'h00, 0, 0, 0));
		`CHK(switch_on, 6'h01)
		$display("Supply and thermal done");
		prewarn_cool = 1'b0;
		prewarn_hot = 1'b1;
		w(8);
		prewarn_hot = 1'b0;
		operate_enable = 1'b0;
		w(8);
		`CHK(switch_on, 6'h00)
		operate_enable = 1'b1;
		w(600);
		rd(ctl(1, 6'h3F, 0), 16'h0000);
		`CHK(switch_on, 6'h3F)
		$display("Standby done");
		results;
	end
endmodule
